// ===== hdl/hcg_dev.sv
// Functional notes
// - One handshake interface per clock domain
// - Request in; acknowledge and activity out
// - On request block entry, drain outstanding
// - Acknowledge only after domain has quiesced
// - Controller may gate once acknowledge low
// - No denial; acknowledge always permits gating
// - Activity output shows interface status
// - Bus-without-stall ports own domain
// - Such ports cannot refuse; clock-off loses
// - System keeps such ports idle before gating
// - Peripheral-bus crossing kept clocked by system
// - Register domain requests target clocks automatically
// - Register domain has own handshake
// - All crossings between domains asynchronous
`timescale 1ns/1ps
`default_nettype none
module hcg_dev #(
  parameter int CNT_W = hcg_pkg::OUTST_W,
  // Set for a port that cannot stall an issued address; it owns its domain
  parameter bit NO_STALL_PORT = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  hcg_lp_if.dev lp,
  input wire logic txn_req_in,
  input wire logic txn_done_in,
  input wire logic wake_in,
  output logic txn_accept_out,
  output logic quiet_out,
  output logic lost_out
);
  hcg_pkg::hcg_state_t state_r;
  hcg_pkg::hcg_state_t state_nxt;
  logic [CNT_W-1:0] outst_r;
  logic [CNT_W-1:0] outst_nxt;
  logic ack_r;
  logic ack_nxt;
  logic act_r;
  logic act_nxt;
  logic accept_r;
  logic accept_nxt;
  logic quiet_r;
  logic quiet_nxt;
  logic lost_r;
  logic lost_nxt;
  logic req_s;
  logic wake_s;

  // True while the domain runs its clock freely
  function automatic logic is_run(input hcg_pkg::hcg_state_t st);
    return st == hcg_pkg::HCG_RUN;
  endfunction

  // True once the clock may go; there is no denial path
  function automatic logic is_gated(input hcg_pkg::hcg_state_t st);
    return st == hcg_pkg::HCG_STOPPED;
  endfunction

  // Saturating step: a full counter must never wrap to look drained
  function automatic logic [CNT_W-1:0] cnt_step(
    input logic [CNT_W-1:0] cnt,
    input logic inc,
    input logic dec
  );
    logic [CNT_W-1:0] res;
    res = cnt;
    if (inc && !dec && (cnt != '1)) begin
      res = cnt + CNT_W'(1);
    end else if (dec && !inc && (cnt != '0)) begin
      res = cnt - CNT_W'(1);
    end
    return res;
  endfunction

  // Request from the controller's domain is synchronised
  hcg_sync u_req_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(~lp.csysreq),
    .rst_val_in(1'b1),
    .q_out(req_s)
  );
  // Wake from another domain, e.g. the register domain
  hcg_sync u_wake_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(wake_in),
    .rst_val_in(1'b0),
    .q_out(wake_s)
  );

  // Entry also shuts while the counter is full, so nothing goes uncounted
  wire room = (outst_r != '1);
  wire entry_ok = is_run(state_r) && req_s && room;
  wire take = txn_req_in && entry_ok;
  wire done = txn_done_in && (outst_r != '0);
  wire drained = (outst_nxt == '0);
  wire pending = txn_req_in || wake_s;
  wire run_nxt = is_run(state_nxt);
  wire gated_nxt = is_gated(state_nxt);

  assign outst_nxt = cnt_step(outst_r, take, done);
  // Acknowledge low only from the stopped state; never a denial
  assign ack_nxt = !gated_nxt;
  // Active while running, draining or with work waiting
  assign act_nxt = run_nxt || (outst_nxt != '0) || pending;
  assign accept_nxt = run_nxt && req_s && (outst_nxt != '1);
  assign quiet_nxt = gated_nxt;
  // A port without stall cannot refuse: flag the lost address
  assign lost_nxt = NO_STALL_PORT && txn_req_in && !entry_ok;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      hcg_pkg::HCG_RUN: begin
        if (!req_s) begin
          state_nxt = hcg_pkg::HCG_DRAIN;
        end
      end
      hcg_pkg::HCG_DRAIN: begin
        if (drained) begin
          state_nxt = hcg_pkg::HCG_STOPPED;
        end
      end
      hcg_pkg::HCG_STOPPED: begin
        if (req_s) begin
          state_nxt = hcg_pkg::HCG_RUN;
        end
      end
      default: state_nxt = hcg_pkg::HCG_RUN;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_r <= hcg_pkg::HCG_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      outst_r <= '0;
    end else begin
      outst_r <= outst_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ack_r <= hcg_pkg::RST_SYSACK;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      act_r <= hcg_pkg::RST_ACTIVE;
    end else begin
      act_r <= act_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      accept_r <= 1'b0;
    end else begin
      accept_r <= accept_nxt;
    end
  end

  // Kept as its own flop so the pin does not hang off an inverter
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      quiet_r <= ~hcg_pkg::RST_SYSACK;
    end else begin
      quiet_r <= quiet_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      lost_r <= 1'b0;
    end else begin
      lost_r <= lost_nxt;
    end
  end

  assign lp.csysack = ack_r;
  assign lp.cactive = act_r;
  assign txn_accept_out = accept_r;
  assign quiet_out = quiet_r;
  assign lost_out = lost_r;
endmodule
`default_nettype wire

// ===== hdl/hcg_pkg.sv
package hcg_pkg;
  // Synchroniser depth for every crossing into a domain
  localparam int SYNC_STAGES = 2;
  // Width of the outstanding-transaction counter
  localparam int OUTST_W = 8;
  // Reset levels of the handshake (run state: request and acknowledge high)
  localparam logic RST_SYSREQ = 1'b1;
  localparam logic RST_SYSACK = 1'b1;
  localparam logic RST_ACTIVE = 1'b1;
  typedef enum logic [1:0] {
    HCG_RUN,
    HCG_DRAIN,
    HCG_STOPPED
  } hcg_state_t;
endpackage

// ===== hdl/hcg_lp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hcg_lp_if;
  logic csysreq;
  logic csysack;
  logic cactive;
  modport dev (input csysreq, output csysack, output cactive);
  modport ctl (output csysreq, input csysack, input cactive);
endinterface
`default_nettype wire

// ===== hdl/hcg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module hcg_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic d_in,
  input wire logic rst_val_in,
  output logic q_out
);
  logic meta_r;
  logic q_r;
  // First stage is read only by the second
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end
  assign q_out = q_r ^ rst_val_in;
endmodule
`default_nettype wire

// ===== hdl/hcg_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module hcg_ctl (
  input wire logic clk_in,
  input wire logic rst_b_in,
  hcg_lp_if.ctl lp,
  input wire logic sleep_in,
  output logic clk_en_out,
  output logic busy_out
);
  logic req_r;
  logic en_r;
  logic busy_r;
  logic ack_s;
  logic act_s;
  hcg_sync u_ack_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(~lp.csysack),
    .rst_val_in(1'b1),
    .q_out(ack_s)
  );
  hcg_sync u_act_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(~lp.cactive),
    .rst_val_in(1'b1),
    .q_out(act_s)
  );
  wire stopped = !req_r && !ack_s;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      req_r <= hcg_pkg::RST_SYSREQ;
      en_r <= 1'b1;
      busy_r <= hcg_pkg::RST_ACTIVE;
    end else begin
      busy_r <= act_s;
      // Gate only after ack falls and activity is low; activity reopens the clock
      if (stopped) begin
        en_r <= act_s ? 1'b1 : 1'b0;
      end
      // Exit: restore clock first, then raise request
      if (!req_r && !ack_s && act_s && en_r) begin
        req_r <= 1'b1;
      // Activity stays high while running, so entry must not wait on it
      end else if (req_r && ack_s && sleep_in) begin
        req_r <= 1'b0;
      end
    end
  end
  assign lp.csysreq = req_r;
  assign clk_en_out = en_r;
  assign busy_out = busy_r;
endmodule
`default_nettype wire

// ===== bench/hcg_lp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hcg_lp_chk (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic csysreq,
  input wire logic csysack,
  input wire logic cactive
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_run;
    csysreq && csysack;
  endsequence
  sequence s_exit;
    csysreq && !csysack;
  endsequence
  a_ack_fall_req: assert property ($fell(csysack) |-> !csysreq)
    else $error("ack fell without request");
  a_ack_fall_lag: assert property ($fell(csysack) |-> !$past(csysreq, 2))
    else $error("ack fell before request synced");
  a_ack_rise_req: assert property ($rose(csysack) |-> $past(csysreq, 2))
    else $error("ack rose without request");
  a_ack_hold_low: assert property (!csysack && !csysreq |=> !csysack)
    else $error("ack left low state early");
  a_ack_rise_bound: assert property (s_exit |-> ##[1:6] csysack)
    else $error("ack did not return");
  a_active_run: assert property (s_run ##1 s_run |-> cactive)
    else $error("activity low while running");
  a_req_after_ack: assert property ($fell(csysreq) |-> csysack)
    else $error("request dropped while gated");
endmodule
`default_nettype wire

// ===== bench/hier_clock_gate_lp_iface_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hier_clock_gate_lp_iface_tb;
  logic clk_in = 0, rst_b_in = 0, req = 0, done = 0, wake = 0, sleep = 0, ack_d = 1;
  int err_total = 0, checked = 0, seed = 64, n, k, got;
  logic exp_q[$];
  logic acc, clk_en, quiet, lost, busy;
  hcg_lp_if lp ();
  hcg_dev #(.NO_STALL_PORT(1'b1)) hcg_dev_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .lp(lp.dev), .txn_req_in(req), .txn_done_in(done), .wake_in(wake), .txn_accept_out(acc),
    .quiet_out(quiet), .lost_out(lost));
  hcg_ctl hcg_ctl_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .lp(lp.ctl), .sleep_in(sleep),
    .clk_en_out(clk_en), .busy_out(busy));
  hcg_lp_chk hcg_lp_chk_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .csysreq(lp.csysreq),
    .csysack(lp.csysack), .cactive(lp.cactive));
  always #4 clk_in = ~clk_in;
  task automatic chk(input string s, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %b seen %b", s, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Every acknowledge edge consumes the oldest note
  always @(posedge clk_in) begin
    ack_d <= lp.csysack;
    if (rst_b_in && lp.csysack !== ack_d) begin
      if (exp_q.size() == 0) chk("ack spurious", lp.csysack, ack_d);
      else chk("ack", lp.csysack, exp_q.pop_front());
    end
  end
  task automatic wait_ack(input logic v);
    for (n = 0; n < 60 && lp.csysack !== v; n++) @(posedge clk_in);
    if (n == 60) begin
      err_total++;
      wrap_up();
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1;
    repeat (4) @(posedge clk_in);
    chk("act", lp.cactive, 1);
    for (int i = 0; i < 4; i++) begin
      k = 1 + $unsigned($random(seed)) % 3;
      got = 0;
      req <= 1;
      for (n = 0; n < 40 && got < k; n++) begin
        @(posedge clk_in);
        got += acc;
      end
      if (got < k) begin
        err_total++;
        wrap_up();
      end
      req <= 0;
      sleep <= 1;
      repeat (4) @(posedge clk_in);
      // Refused while draining: must not add to the count
      req <= 1;
      repeat (4) @(posedge clk_in);
      req <= 0;
      chk("entry", acc, 0);
      chk("lost", lost, 1);
      chk("busy ack", lp.csysack, 1);
      exp_q.push_back(0);
      repeat ($unsigned($random(seed)) % 4) @(posedge clk_in);
      done <= 1;
      repeat (k) @(posedge clk_in);
      done <= 0;
      wait_ack(0);
      chk("quiet", quiet, 1);
      for (n = 0; n < 20 && clk_en !== 0; n++) @(posedge clk_in);
      chk("gated", clk_en, 0);
      chk("busy", busy, 0);
      if (clk_en !== 0) wrap_up();
      wake <= 1;
      repeat (6) @(posedge clk_in);
      chk("wake act", lp.cactive, 1);
      exp_q.push_back(1);
      sleep <= 0;
      wait_ack(1);
      wake <= 0;
      chk("clk on", clk_en, 1);
    end
    repeat (4) @(posedge clk_in);
    wrap_up();
  end
endmodule
`default_nettype wire
